// ==== src/spi_reg_pkg.sv ====
// constants for the serial register access slave
package spi_reg_pkg;
   // ==========================================
   // word format
   localparam int unsigned WORD_BITS     = 16;
   localparam int unsigned BIT_CNT_W     = 5;
   localparam logic [4:0]  LAST_BIT      = 5'h0F;
   localparam int unsigned DIR_BIT       = 15;
   localparam int unsigned PAGE_HI_BIT   = 13;
   localparam int unsigned PAGE_LO_BIT   = 12;
   localparam int unsigned START_HI_BIT  = 10;
   localparam int unsigned START_LO_BIT  = 6;
   localparam int unsigned END_HI_BIT    = 4;
   localparam int unsigned END_LO_BIT    = 0;
   localparam logic [15:0] ZERO_WORD     = 16'h0000;
   localparam logic [4:0]  INDEX_RESET   = 5'h00;
   localparam logic [1:0]  PAGE_RESET    = 2'h0;
   // ==========================================
   // transfer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_CMD   = 4'h2,
      ST_DATA  = 4'h4,
      ST_DRAIN = 4'h8
   } xfer_state_e;
endpackage : spi_reg_pkg

// ==== src/spi_pin_sync.sv ====
// two-stage synchroniser with edge detection for the serial pins
`timescale 1ns/1ps
module spi_pin_sync (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic sclk,
   input  wire logic ss_n,
   input  wire logic mosi,
   output logic      sclk_rise,
   output logic      sclk_fall,
   output logic      ss_n_level,
   output logic      ss_fall,
   output logic      mosi_level
);
   // ==========================================
   // state
   typedef struct packed {
      logic [2:0] sclk_pipe;
      logic [2:0] ss_pipe;
      logic [1:0] mosi_pipe;
   } sync_s;

   sync_s state;
   sync_s next_state;

   always_comb begin
      next_state           = state;
      // stage 0 is read only by stage 1
      next_state.sclk_pipe = {state.sclk_pipe[1:0], sclk};
      next_state.ss_pipe   = {state.ss_pipe[1:0], ss_n};
      next_state.mosi_pipe = {state.mosi_pipe[0], mosi};
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state.sclk_pipe <= 3'h0;
         state.ss_pipe   <= 3'h7;
         state.mosi_pipe <= 2'h0;
      end else begin
         state <= next_state;
      end
   end

   assign sclk_rise  = state.sclk_pipe[1] & ~state.sclk_pipe[2];
   assign sclk_fall  = ~state.sclk_pipe[1] & state.sclk_pipe[2];
   assign ss_n_level = state.ss_pipe[1];
   assign ss_fall    = ~state.ss_pipe[1] & state.ss_pipe[2];
   assign mosi_level = state.mosi_pipe[1];
endmodule : spi_pin_sync

// ==== src/spi_register_access_slave.sv ====
// serial register access slave: command decode, word shifting, register port
// ==========================================
`timescale 1ns/1ps
module spi_register_access_slave (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        sclk,
   input  wire logic        ss_n,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe,
   output logic             reg_write,
   output logic             reg_read,
   output logic [1:0]       reg_page,
   output logic [4:0]       reg_index,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   // ==========================================
   // pin synchronisation
   logic sclk_rise;
   logic sclk_fall;
   logic ss_n_level;
   logic ss_fall;
   logic mosi_level;

   spi_pin_sync u_sync (
      .clk        (clk),
      .reset_n    (reset_n),
      .sclk       (sclk),
      .ss_n       (ss_n),
      .mosi       (mosi),
      .sclk_rise  (sclk_rise),
      .sclk_fall  (sclk_fall),
      .ss_n_level (ss_n_level),
      .ss_fall    (ss_fall),
      .mosi_level (mosi_level)
   );

   // ==========================================
   // state
   typedef struct packed {
      spi_reg_pkg::xfer_state_e mode;
      logic [4:0]               bit_count;
      logic [15:0]              rx_shift;
      logic [15:0]              tx_shift;
      logic                     is_read;
      logic [4:0]               cur_index;
      logic [4:0]               end_index;
      logic                     last_word;
      logic                     advance;
      logic                     miso;
      logic                     miso_oe;
      logic                     reg_write;
      logic                     reg_read;
      logic [1:0]               reg_page;
      logic [15:0]              reg_wdata;
   } slave_s;

   slave_s state;
   slave_s next_state;

   // end not above start collapses the range to the start register
   function automatic logic single_access(input logic [4:0] start_idx, input logic [4:0] end_idx);
      single_access = (end_idx <= start_idx);
   endfunction : single_access

   logic [15:0] word_in;

   always_comb begin
      next_state           = state;
      next_state.reg_write = 1'b0;
      next_state.reg_read  = 1'b0;
      word_in              = {state.rx_shift[14:0], mosi_level};
      if (ss_n_level) begin
         // deselect drops any partial word and ends the operation
         next_state.mode      = spi_reg_pkg::ST_IDLE;
         next_state.bit_count = spi_reg_pkg::INDEX_RESET;
         next_state.miso_oe   = 1'b0;
         next_state.advance   = 1'b0;
         next_state.miso      = 1'b0;
      end else begin
         next_state.miso_oe = 1'b1;
         if (ss_fall) begin
            next_state.mode      = spi_reg_pkg::ST_CMD;
            next_state.bit_count = spi_reg_pkg::INDEX_RESET;
            next_state.tx_shift  = spi_reg_pkg::ZERO_WORD;
            next_state.miso      = 1'b0;
         end else if (state.mode != spi_reg_pkg::ST_IDLE) begin
            if (state.advance) begin
               // index steps one cycle after the write strobe, and the next read goes out on that same edge
               next_state.advance   = 1'b0;
               next_state.cur_index = state.cur_index + 5'h01;
               next_state.last_word = (state.cur_index + 5'h01) == state.end_index;
               next_state.reg_read  = state.is_read;
            end
            if (sclk_rise) begin
               // outgoing bit changes on the rising edge, msb first
               next_state.miso     = state.tx_shift[15];
               next_state.tx_shift = {state.tx_shift[14:0], 1'b0};
            end
            if (sclk_fall) begin
               next_state.rx_shift  = word_in;
               next_state.bit_count = state.bit_count + 5'h01;
               if (state.bit_count == spi_reg_pkg::LAST_BIT) begin
                  next_state.bit_count = spi_reg_pkg::INDEX_RESET;
                  unique case (state.mode)
                     spi_reg_pkg::ST_CMD: begin
                        next_state.is_read   = word_in[spi_reg_pkg::DIR_BIT];
                        next_state.reg_page  = {word_in[spi_reg_pkg::PAGE_HI_BIT], word_in[spi_reg_pkg::PAGE_LO_BIT]};
                        next_state.cur_index = word_in[spi_reg_pkg::START_HI_BIT:spi_reg_pkg::START_LO_BIT];
                        next_state.end_index = word_in[spi_reg_pkg::END_HI_BIT:spi_reg_pkg::END_LO_BIT];
                        next_state.last_word = single_access(word_in[spi_reg_pkg::START_HI_BIT:spi_reg_pkg::START_LO_BIT],
                                                             word_in[spi_reg_pkg::END_HI_BIT:spi_reg_pkg::END_LO_BIT]);
                        next_state.mode      = spi_reg_pkg::ST_DATA;
                        next_state.reg_read  = word_in[spi_reg_pkg::DIR_BIT];
                     end
                     spi_reg_pkg::ST_DATA: begin
                        // a write lands only after all 16 bits arrive
                        next_state.reg_write = ~state.is_read;
                        next_state.reg_wdata = word_in;
                        if (state.last_word) begin
                           next_state.mode = spi_reg_pkg::ST_DRAIN;
                        end else begin
                           // moving the index with the strobe would send the write to the next register
                           next_state.advance = 1'b1;
                        end
                     end
                     spi_reg_pkg::ST_DRAIN: begin
                        next_state.mode = spi_reg_pkg::ST_DRAIN;
                     end
                     default: begin
                        next_state.mode = spi_reg_pkg::ST_IDLE;
                     end
                  endcase
               end
            end
         end
      end
      // read data arrives one cycle after the request, well before next rise
      if (state.reg_read) begin
         next_state.tx_shift = reg_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state.mode      <= spi_reg_pkg::ST_IDLE;
         state.bit_count <= spi_reg_pkg::INDEX_RESET;
         state.rx_shift  <= spi_reg_pkg::ZERO_WORD;
         state.tx_shift  <= spi_reg_pkg::ZERO_WORD;
         state.is_read   <= 1'b0;
         state.cur_index <= spi_reg_pkg::INDEX_RESET;
         state.end_index <= spi_reg_pkg::INDEX_RESET;
         state.last_word <= 1'b0;
         state.advance   <= 1'b0;
         state.miso      <= 1'b0;
         state.miso_oe   <= 1'b0;
         state.reg_write <= 1'b0;
         state.reg_read  <= 1'b0;
         state.reg_page  <= spi_reg_pkg::PAGE_RESET;
         state.reg_wdata <= spi_reg_pkg::ZERO_WORD;
      end else begin
         state <= next_state;
      end
   end

   assign miso      = state.miso;
   assign miso_oe   = state.miso_oe;
   assign reg_write = state.reg_write;
   assign reg_read  = state.reg_read;
   assign reg_page  = state.reg_page;
   assign reg_index = state.cur_index;
   assign reg_wdata = state.reg_wdata;

   // ==========================================
   // checks
   AST_OE_OFF: assert property (@(posedge clk) disable iff (!reset_n) ss_n_level |=> !miso_oe)
      else $error("miso driven while deselected");
   AST_NO_WRITE_DESELECT: assert property (@(posedge clk) disable iff (!reset_n) ss_n_level |=> !reg_write)
      else $error("write issued while deselected");
   AST_WRITE_FULL_WORD: assert property (@(posedge clk) disable iff (!reset_n)
      reg_write |-> $past(sclk_fall) && $past(state.bit_count) == spi_reg_pkg::LAST_BIT)
      else $error("write from partial word");
   AST_CMD_AFTER_SELECT: assert property (@(posedge clk) disable iff (!reset_n)
      ss_fall && !ss_n_level |=> state.mode == spi_reg_pkg::ST_CMD && state.bit_count == 5'h00)
      else $error("select did not start command");
   AST_COUNT_LIMIT: assert property (@(posedge clk) disable iff (!reset_n) state.bit_count <= spi_reg_pkg::LAST_BIT)
      else $error("bit count overran");
   AST_DRAIN_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
      state.mode == spi_reg_pkg::ST_DRAIN && sclk_rise && !ss_n_level && !state.reg_read |=> !miso)
      else $error("nonzero data past end");
   AST_ABORT_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
      ss_n_level |=> state.mode == spi_reg_pkg::ST_IDLE ##1 !reg_read)
      else $error("operation survived deselect");
   AST_READ_NO_WRITE: assert property (@(posedge clk) disable iff (!reset_n) state.is_read && reg_write |-> 1'b0)
      else $error("write during read operation");
   AST_MISO_ON_RISE: assert property (@(posedge clk) disable iff (!reset_n)
      !ss_n_level && !$past(ss_n_level) && !$past(sclk_rise) && !$past(ss_fall) |-> $stable(miso))
      else $error("miso changed off rising edge");
   AST_WRITE_INDEX_HELD: assert property (@(posedge clk) disable iff (!reset_n) reg_write |-> $stable(reg_index))
      else $error("index moved with write strobe");
   AST_OE_ON: assert property (@(posedge clk) disable iff (!reset_n) !ss_n_level |=> miso_oe)
      else $error("miso not driven while selected");
   AST_DRAIN_NO_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
      state.mode == spi_reg_pkg::ST_DRAIN && $past(state.mode) == spi_reg_pkg::ST_DRAIN |-> !reg_write)
      else $error("write past end register");
endmodule : spi_register_access_slave

// ==== test/spi_host_model.sv ====
// serial bus master model for the register access slave
`timescale 1ns/1ps
module spi_host_model (
   output logic      sclk,
   output logic      ss_n,
   output logic      mosi,
   input  wire logic miso_pin
);
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end
   // ==========================================
   // framing: lead and lag well above four system clocks
   task open_frame();
      #150 ss_n = 1'b0;
      #150;
   endtask : open_frame
   task close_frame();
      #150 ss_n = 1'b1;
      mosi = ~mosi; // released line must not keep its last value
      #400;
   endtask : close_frame
   // nbits of w, msb first; 16 for a whole word, fewer to cut it short
   task xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
      r = 16'h0000;
      for (int i = 15; i > 15 - nbits; i--) begin
         sclk = 1'b1;
         mosi = w[i];
         #100 sclk = 1'b0;
         r[i] = miso_pin;
         #100;
      end
   endtask : xfer
endmodule : spi_host_model

// ==== test/spi_register_access_slave_bench.sv ====
// self-checking bench for the register access slave
`timescale 1ns/1ps
module spi_register_access_slave_bench;
   logic        clk, reset_n, sclk, ss_n, mosi, miso, miso_oe, reg_write, reg_read;
   logic [1:0]  reg_page;
   logic [4:0]  reg_index;
   logic [15:0] reg_wdata, reg_rdata, r;
   wire         miso_pin;
   int          mismatches, n_checks;
   logic [22:0] wq[$];
   logic [6:0]  rq[$];
   // ==========================================
   // register file stand-in and pin resolution
   function automatic logic [15:0] exp_rd(input logic [1:0] p, input logic [4:0] i);
      return {4'hA, 2'h0, p, 3'h0, i};
   endfunction : exp_rd
   assign reg_rdata = exp_rd(reg_page, reg_index);
   assign miso_pin  = miso_oe ? miso : 1'bz;
   // strobes are looked at mid-cycle, where they stand settled
   always @(negedge clk) if (reg_write === 1'b1) wq.push_back({reg_page, reg_index, reg_wdata});
   always @(negedge clk) if (reg_read === 1'b1) rq.push_back({reg_page, reg_index});
   spi_register_access_slave u_spi_register_access_slave (.clk(clk), .reset_n(reset_n), .sclk(sclk),
      .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .reg_write(reg_write), .reg_read(reg_read),
      .reg_page(reg_page), .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   spi_host_model u_spi_host_model (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_pin(miso_pin));
   // ==========================================
   // helpers
   task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task end_sim();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   // ==========================================
   // scenarios
   task automatic t_write_range();
      wq.delete();
      u_spi_host_model.open_frame();
      u_spi_host_model.xfer(16'h10C5, 16, r);
      for (int k = 0; k < 4; k++) u_spi_host_model.xfer(16'hC3A0 + 16'(k), 16, r);
      u_spi_host_model.close_frame();
      chk("write count", 23'h3, 23'(wq.size()));
      for (int k = 0; k < 3; k++) chk("write entry", {2'h1, 5'(3 + k), 16'hC3A0 + 16'(k)}, wq[k]);
   endtask : t_write_range
   task automatic t_read_range();
      rq.delete();
      u_spi_host_model.open_frame();
      chk("oe selected", 23'h1, 23'(miso_oe));
      u_spi_host_model.xfer(16'h8083, 16, r);
      for (int k = 0; k < 3; k++) begin
         u_spi_host_model.xfer(16'h0000, 16, r);
         chk("read word", (k < 2) ? 23'(exp_rd(2'h0, 5'(2 + k))) : 23'h0, 23'(r));
      end
      u_spi_host_model.close_frame();
      chk("oe released", 23'h0, 23'(miso_oe));
      chk("read count", 23'h2, 23'(rq.size()));
      for (int k = 0; k < 2; k++) chk("read entry", 23'({2'h0, 5'(2 + k)}), 23'(rq[k]));
   endtask : t_read_range
   task automatic t_single();
      wq.delete();
      u_spi_host_model.open_frame();
      u_spi_host_model.xfer(16'h10C2, 16, r);
      u_spi_host_model.xfer(16'h5A5A, 16, r);
      u_spi_host_model.xfer(16'hA5A5, 16, r);
      u_spi_host_model.close_frame();
      chk("single count", 23'h1, 23'(wq.size()));
      chk("single entry", {2'h1, 5'h03, 16'h5A5A}, wq[0]);
   endtask : t_single
   task automatic t_abort();
      wq.delete();
      u_spi_host_model.open_frame();
      u_spi_host_model.xfer(16'h1045, 16, r);
      u_spi_host_model.xfer(16'h1111, 16, r);
      u_spi_host_model.xfer(16'h2222, 9, r);
      u_spi_host_model.close_frame();
      chk("cut write count", 23'h1, 23'(wq.size()));
      chk("cut write entry", {2'h1, 5'h01, 16'h1111}, wq[0]);
      u_spi_host_model.open_frame();
      u_spi_host_model.xfer(16'h8043, 16, r);
      u_spi_host_model.xfer(16'h0000, 8, r);
      u_spi_host_model.close_frame();
      u_spi_host_model.open_frame();
      u_spi_host_model.xfer(16'h9080, 16, r);
      u_spi_host_model.xfer(16'h0000, 16, r);
      u_spi_host_model.close_frame();
      chk("read after cut", 23'(exp_rd(2'h1, 5'h02)), 23'(r));
      chk("no stray write", 23'h1, 23'(wq.size()));
   endtask : t_abort
   // ==========================================
   // clock, reset, sequence, watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      mismatches = 0;
      n_checks = 0;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("oe after reset", 23'h0, 23'(miso_oe));
      t_write_range();
      t_read_range();
      t_single();
      t_abort();
      end_sim();
   end
   initial begin
      #500000;
      mismatches++;
      end_sim();
   end
endmodule : spi_register_access_slave_bench
